// [core/fps_pkg.sv]
// Package for the fault protection supervisor: states, carriers, timing constants
package fps_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OLP_BLANK_MS = 24;
  localparam int unsigned OLP_BLANK_CYC = OLP_BLANK_MS * (CLK_HZ / 1000);
  localparam int unsigned OVP_BLANK_US = 10;
  localparam int unsigned OVP_BLANK_CYC = OVP_BLANK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W = 20;

  typedef enum logic [3:0] {
    FPS_CHARGE  = 4'h1,
    FPS_RUN     = 4'h2,
    FPS_RESTART = 4'h4,
    FPS_LATCHED = 4'h8
  } fps_state_t;

  // Comparator results, raw asynchronous levels; synchronised inside the supervisor
  typedef struct packed {
    logic supply_overvoltage;
    logic supply_undervoltage;
    logic supply_turn_on;
    logic reg_overload;
    logic output_overvoltage;
    logic shorted_winding;
  } fps_cmp_t;

  typedef struct packed {
    logic overload_open_loop_fault;
    logic output_ovp_fault;
    logic short_winding_fault;
    logic supply_fault;
  } fps_flags_t;
endpackage

// [core/fps_supervisor.sv]
// Fault protection supervisor: auto-restart and latch-off control
`timescale 1ns/10ps
module fps_supervisor #(
  parameter int unsigned OLP_CYC = fps_pkg::OLP_BLANK_CYC,
  parameter int unsigned OVP_CYC = fps_pkg::OVP_BLANK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire fps_pkg::fps_cmp_t i_cmp,
  input wire logic i_switch_on,
  input wire logic i_burst_mode,
  output logic o_gate_enable,
  output logic o_soft_start,
  output logic o_power_cell_en,
  output fps_pkg::fps_state_t o_state,
  output fps_pkg::fps_flags_t o_flags
);
  localparam logic [fps_pkg::CNT_W-1:0] OLP_LAST = fps_pkg::CNT_W'(OLP_CYC - 1);
  localparam logic [fps_pkg::CNT_W-1:0] OVP_LAST = fps_pkg::CNT_W'(OVP_CYC - 1);

  fps_pkg::fps_cmp_t cmp_meta;
  fps_pkg::fps_cmp_t cmp;
  logic sw_meta;
  logic sw_on;
  logic burst_meta;
  logic burst;
  fps_pkg::fps_state_t state;
  fps_pkg::fps_state_t next_state;
  logic [fps_pkg::CNT_W-1:0] olp_cnt;
  logic [fps_pkg::CNT_W-1:0] next_olp_cnt;
  logic [fps_pkg::CNT_W-1:0] ovp_cnt;
  logic [fps_pkg::CNT_W-1:0] next_ovp_cnt;
  logic soft_start;

  // Comparators are asynchronous analog outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_meta <= '0;
      cmp <= '0;
      sw_meta <= 1'b0;
      sw_on <= 1'b0;
      burst_meta <= 1'b0;
      burst <= 1'b0;
    end else begin
      cmp_meta <= i_cmp;
      cmp <= cmp_meta;
      sw_meta <= i_switch_on;
      sw_on <= sw_meta;
      burst_meta <= i_burst_mode;
      burst <= burst_meta;
    end
  end

  wire running = (state == fps_pkg::FPS_RUN);
  wire supply_bad = cmp.supply_overvoltage | cmp.supply_undervoltage;
  wire olp_cond = running & cmp.reg_overload;
  // Sampled only in off-time; ringing during on-time would give false trips
  wire ovp_cond = running & ~sw_on & cmp.output_overvoltage;
  wire sw_trip = running & sw_on & cmp.shorted_winding;
  wire olp_trip = olp_cond & (olp_cnt == OLP_LAST);
  wire ovp_trip = ovp_cond & (ovp_cnt == OVP_LAST);
  wire latch_trip = ovp_trip | sw_trip;

  assign next_olp_cnt = olp_cond ? olp_cnt + 1'b1 : '0;
  assign next_ovp_cnt = ovp_cond ? ovp_cnt + 1'b1 : '0;

  always_comb begin
    next_state = state;
    case (state)
      fps_pkg::FPS_CHARGE: begin
        if (cmp.supply_turn_on && !supply_bad) begin
          next_state = fps_pkg::FPS_RUN;
        end
      end
      fps_pkg::FPS_RUN: begin
        if (latch_trip) begin
          next_state = fps_pkg::FPS_LATCHED;
        end else if (supply_bad || olp_trip) begin
          next_state = fps_pkg::FPS_RESTART;
        end
      end
      fps_pkg::FPS_RESTART: begin
        if (cmp.supply_undervoltage) begin
          next_state = fps_pkg::FPS_CHARGE;
        end
      end
      fps_pkg::FPS_LATCHED: begin
        if (cmp.supply_undervoltage) begin
          next_state = fps_pkg::FPS_CHARGE;
        end
      end
      default: next_state = fps_pkg::FPS_CHARGE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= fps_pkg::FPS_CHARGE;
      olp_cnt <= '0;
      ovp_cnt <= '0;
      soft_start <= 1'b0;
    end else begin
      state <= next_state;
      olp_cnt <= (next_state == fps_pkg::FPS_RUN) ? next_olp_cnt : '0;
      ovp_cnt <= (next_state == fps_pkg::FPS_RUN) ? next_ovp_cnt : '0;
      soft_start <= (state == fps_pkg::FPS_CHARGE) && (next_state == fps_pkg::FPS_RUN);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_gate_enable <= 1'b0;
      o_soft_start <= 1'b0;
      o_power_cell_en <= 1'b1;
      o_state <= fps_pkg::FPS_CHARGE;
      o_flags <= '0;
    end else begin
      o_gate_enable <= (next_state == fps_pkg::FPS_RUN);
      o_soft_start <= soft_start;
      // Cell only sources when supply sags below hold level, so enabling is harmless
      o_power_cell_en <= (next_state == fps_pkg::FPS_CHARGE)
        | (next_state == fps_pkg::FPS_LATCHED)
        | ((next_state == fps_pkg::FPS_RUN) & burst);
      o_state <= next_state;
      o_flags.overload_open_loop_fault <= olp_trip | (o_flags.overload_open_loop_fault
        & (next_state != fps_pkg::FPS_RUN));
      o_flags.output_ovp_fault <= ovp_trip | (o_flags.output_ovp_fault
        & (next_state == fps_pkg::FPS_LATCHED));
      o_flags.short_winding_fault <= sw_trip | (o_flags.short_winding_fault
        & (next_state == fps_pkg::FPS_LATCHED));
      o_flags.supply_fault <= (running & supply_bad) | (o_flags.supply_fault
        & (next_state != fps_pkg::FPS_RUN));
    end
  end

  property p_olp_blank;
    @(posedge i_clk) disable iff (i_rst)
    (olp_cond && olp_cnt == OLP_LAST && !latch_trip) |=> (state == fps_pkg::FPS_RESTART);
  endproperty
  a_olp_blank: assert property (p_olp_blank) else $error("overload not restarted");

  property p_timer_clear;
    @(posedge i_clk) disable iff (i_rst)
    (!olp_cond) |=> (olp_cnt == '0);
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("overload timer kept");

  property p_sw_latch;
    @(posedge i_clk) disable iff (i_rst)
    sw_trip |=> (state == fps_pkg::FPS_LATCHED) ##0 !o_gate_enable;
  endproperty
  a_sw_latch: assert property (p_sw_latch) else $error("short winding not latched");

  property p_ovp_off_only;
    @(posedge i_clk) disable iff (i_rst)
    sw_on |=> (ovp_cnt == '0);
  endproperty
  a_ovp_off_only: assert property (p_ovp_off_only) else $error("ovp sampled on");

  property p_ovp_latch;
    @(posedge i_clk) disable iff (i_rst)
    ovp_trip |=> (state == fps_pkg::FPS_LATCHED);
  endproperty
  a_ovp_latch: assert property (p_ovp_latch) else $error("ovp not latched");

  property p_supply_off;
    @(posedge i_clk) disable iff (i_rst)
    (running && supply_bad) |=> !o_gate_enable;
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("gate on in supply fault");

  property p_latch_hold;
    @(posedge i_clk) disable iff (i_rst)
    (state == fps_pkg::FPS_LATCHED && !cmp.supply_undervoltage)
      |=> (state == fps_pkg::FPS_LATCHED) && o_power_cell_en && !o_gate_enable;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch lost");

  property p_cell_latched;
    @(posedge i_clk) disable iff (i_rst)
    (o_state == fps_pkg::FPS_LATCHED) |-> o_power_cell_en;
  endproperty
  a_cell_latched: assert property (p_cell_latched) else $error("cell off latched");

  property p_burst_cell;
    @(posedge i_clk) disable iff (i_rst)
    (burst && next_state == fps_pkg::FPS_RUN) |=> o_power_cell_en;
  endproperty
  a_burst_cell: assert property (p_burst_cell) else $error("cell off in burst");

  property p_restart_cell;
    @(posedge i_clk) disable iff (i_rst)
    (state == fps_pkg::FPS_RESTART && cmp.supply_undervoltage) |=> o_power_cell_en;
  endproperty
  a_restart_cell: assert property (p_restart_cell) else $error("no recharge");

  property p_soft_start;
    @(posedge i_clk) disable iff (i_rst)
    (state == fps_pkg::FPS_CHARGE && next_state == fps_pkg::FPS_RUN) |=> ##1 o_soft_start;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("no soft start");

  property p_auto_class;
    @(posedge i_clk) disable iff (i_rst)
    (running && olp_trip && !latch_trip) |=> state != fps_pkg::FPS_LATCHED;
  endproperty
  a_auto_class: assert property (p_auto_class) else $error("overload latched");

  property p_uv_restart;
    @(posedge i_clk) disable iff (i_rst)
    (running && cmp.supply_undervoltage && !latch_trip) |=> state == fps_pkg::FPS_RESTART;
  endproperty
  a_uv_restart: assert property (p_uv_restart) else $error("uv missed");

  property p_olp_recognise;
    @(posedge i_clk) disable iff (i_rst)
    (running && cmp.reg_overload && next_state == fps_pkg::FPS_RUN) |=> olp_cnt != '0;
  endproperty
  a_olp_recognise: assert property (p_olp_recognise) else $error("olp not counted");

  property p_sw_recognise;
    @(posedge i_clk) disable iff (i_rst)
    (running && sw_on && cmp.shorted_winding) |=> o_flags.short_winding_fault;
  endproperty
  a_sw_recognise: assert property (p_sw_recognise) else $error("sw flag missing");

  c_start: cover property (@(posedge i_clk) disable iff (i_rst) soft_start);
  c_olp: cover property (@(posedge i_clk) disable iff (i_rst) olp_trip);
  c_latch: cover property (@(posedge i_clk) disable iff (i_rst) latch_trip);
  c_unlatch: cover property (@(posedge i_clk) disable iff (i_rst)
    state == fps_pkg::FPS_LATCHED ##1 state == fps_pkg::FPS_CHARGE);
endmodule // fps_supervisor

// [verification/fps_cmp_model.sv]
// Comparator front end that faces the fault protection supervisor
`timescale 1ns/10ps
module fps_cmp_model (
  input wire logic [8:0] i_vcc_dv,
  input wire logic i_reg_hi,
  input wire logic i_zc_hi,
  input wire logic i_cs_hi,
  output fps_pkg::fps_cmp_t o_cmp
);
  // Supply given in tenths of a volt, compared against fixed trip points
  always_comb begin
    o_cmp.supply_overvoltage = i_vcc_dv > 9'h0fa;
    o_cmp.supply_undervoltage = i_vcc_dv < 9'h06e;
    o_cmp.supply_turn_on = i_vcc_dv > 9'h0dc;
    o_cmp.reg_overload = i_reg_hi;
    o_cmp.output_overvoltage = i_zc_hi;
    o_cmp.shorted_winding = i_cs_hi;
  end
endmodule // fps_cmp_model

// [verification/tb_fps_supervisor.sv]
// Self-checking bench for the fault protection supervisor
`timescale 1ns/10ps
module tb_fps_supervisor;
  localparam int OVERLOAD_OPEN_LOOP_FAULT = 16;
  localparam int OVP = 4;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_switch_on = 1'b0;
  logic i_burst_mode = 1'b0;
  logic [8:0] vcc = 9'h000;
  logic reg_hi = 1'b0;
  logic zc_hi = 1'b0;
  logic cs_hi = 1'b0;
  fps_pkg::fps_cmp_t cmp;
  logic o_gate_enable;
  logic o_soft_start;
  logic o_power_cell_en;
  fps_pkg::fps_state_t o_state;
  fps_pkg::fps_flags_t o_flags;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h00000038;
  always #25 i_clk = ~i_clk;
  fps_cmp_model model (.i_vcc_dv(vcc), .i_reg_hi(reg_hi), .i_zc_hi(zc_hi),
    .i_cs_hi(cs_hi), .o_cmp(cmp));
  fps_supervisor #(.OLP_CYC(OVERLOAD_OPEN_LOOP_FAULT), .OVP_CYC(OVP)) dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_cmp(cmp), .i_switch_on(i_switch_on), .i_burst_mode(i_burst_mode),
    .o_gate_enable(o_gate_enable), .o_soft_start(o_soft_start),
    .o_power_cell_en(o_power_cell_en), .o_state(o_state), .o_flags(o_flags));
  function automatic logic [31:0] xorshift(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // Cell on while charging or latched, and in burst while running; restart waits for UV
  function automatic logic exp_cell(fps_pkg::fps_state_t s, logic burst);
    return (s == fps_pkg::FPS_CHARGE) || (s == fps_pkg::FPS_LATCHED)
      || ((s == fps_pkg::FPS_RUN) && burst);
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Bounded wait for a state, then its gate and cell levels
  task automatic reach(fps_pkg::fps_state_t s, int lim);
    int k;
    k = 0;
    while (o_state !== s && k < lim) begin
      @(negedge i_clk);
      k++;
    end
    check(8'(o_state), 8'(s));
    check(8'(o_gate_enable), 8'(s == fps_pkg::FPS_RUN));
    check(8'(o_power_cell_en), 8'(exp_cell(s, i_burst_mode)));
  endtask
  task automatic power_up();
    vcc = 9'h0e6;
    reach(fps_pkg::FPS_RUN, 8);
    cyc(1);
    check(8'(o_soft_start), 8'h01);
    cyc(1);
    check(8'(o_soft_start), 8'h00);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #(50 * 3000);
    error_cnt++;
    print_verdict();
  end
  initial begin
    cyc(8);
    i_rst = 1'b0;
    reach(fps_pkg::FPS_CHARGE, 0);
    check(8'(o_flags), 8'h00);
    power_up();
    i_burst_mode = 1'b1;
    cyc(5);
    check(8'(o_power_cell_en), 8'h01);
    i_burst_mode = 1'b0;
    cyc(5);
    check(8'(o_power_cell_en), 8'h00);
    // Random overload excursions, each shorter than the blanking window
    for (int i = 0; i < 6; i++) begin
      seed = xorshift(seed);
      reg_hi = 1'b1;
      cyc(1 + int'(seed % 32'd14));
      reg_hi = 1'b0;
      cyc(1);
    end
    cyc(4);
    reach(fps_pkg::FPS_RUN, 0);
    reg_hi = 1'b1;
    cyc(OVERLOAD_OPEN_LOOP_FAULT - 2);
    reach(fps_pkg::FPS_RUN, 0);
    reach(fps_pkg::FPS_RESTART, 10);
    check(8'(o_flags), 8'h08);
    reg_hi = 1'b0;
    vcc = 9'h064;
    reach(fps_pkg::FPS_CHARGE, 8);
    power_up();
    check(8'(o_flags), 8'h00);
    vcc = 9'h104;
    reach(fps_pkg::FPS_RESTART, 8);
    check(8'(o_flags), 8'h01);
    vcc = 9'h0e6;
    cyc(8);
    reach(fps_pkg::FPS_RESTART, 0);
    vcc = 9'h064;
    reach(fps_pkg::FPS_CHARGE, 8);
    power_up();
    i_switch_on = 1'b1;
    zc_hi = 1'b1;
    cyc(OVP + 6);
    reach(fps_pkg::FPS_RUN, 0);
    i_switch_on = 1'b0;
    cyc(OVP - 2);
    zc_hi = 1'b0;
    cyc(6);
    reach(fps_pkg::FPS_RUN, 0);
    zc_hi = 1'b1;
    reach(fps_pkg::FPS_LATCHED, OVP + 8);
    check(8'(o_flags), 8'h04);
    zc_hi = 1'b0;
    cyc(8);
    reach(fps_pkg::FPS_LATCHED, 0);
    vcc = 9'h064;
    reach(fps_pkg::FPS_CHARGE, 8);
    check(8'(o_flags), 8'h00);
    power_up();
    cs_hi = 1'b1;
    cyc(8);
    reach(fps_pkg::FPS_RUN, 0);
    i_switch_on = 1'b1;
    reach(fps_pkg::FPS_LATCHED, 8);
    check(8'(o_flags), 8'h02);
    i_switch_on = 1'b0;
    cs_hi = 1'b0;
    print_verdict();
  end
endmodule // tb_fps_supervisor
